// File: tcc_consec_count.sv
`timescale 1ns/10ps
`default_nettype none
// counts consecutive over-limit results of one channel
module tcc_consec_count
  import tcc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sample,
  input wire logic over,
  input wire logic [2:0] need,
  output logic qualified
);
  logic [2:0] count; // consecutive over-limit results so far
  logic [2:0] next_count;
  logic at_max; // counter saturated

  assign at_max = (count == 3'h7);
  assign next_count = over ? (at_max ? count : count + 3'h1) : 3'h0;

  // update on each compared result
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 3'h0;
      qualified <= 1'b0;
    end else if (sample) begin
      count <= next_count;
      qualified <= over && (next_count >= need);
    end
  end
endmodule : tcc_consec_count
`default_nettype wire

// File: tcc_conv_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - in shutdown, trigger write starts one conversion cycle
// - single shot converts only enabled channels
// - after single shot cycle, return to shutdown
// - trigger write data ignored, never stored
// - channel enable read/write, bit0 local, bit1 remote
// - both enables set after reset, clear stops
// - alert after programmed consecutive high results
// - count codes 01h,03h,07h,0Fh; reset 01h
// - ideality correction signed byte, resets zero
// - remote factor 1.008*2088/(2088+adjust)
// - remote offset added to every remote result
// - maker pointer reads fixed maker code
// - shutdown finishes sequence; clear runs continuously
// - any qualified flag latches alert, drives low
module tcc_conv_ctrl
  import tcc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
  parameter int W = TCC_RES_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  // pointer-addressed register port from the serial engine
  input wire logic [7:0] reg_ptr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // configuration shutdown bit from the configuration register
  input wire logic stop_converting_bit,
  // converter handshake
  output logic conv_start,
  output logic conv_remote_sel,
  input wire logic conv_done,
  input wire logic signed [W-1:0] conv_raw,
  input wire logic remote_open,
  // limits and alert service
  input wire logic signed [W-1:0] local_high_limit,
  input wire logic signed [W-1:0] remote_high_limit,
  input wire logic alert_service,
  output logic busy,
  output logic alert_n,
  output logic signed [W-1:0] local_result,
  output logic signed [W-1:0] remote_result
);
  // conversion sequencer states
  typedef enum logic [5:0] {
    TCC_IDLE = 6'b000001,
    TCC_LSTART = 6'b000010,
    TCC_LWAIT = 6'b000100,
    TCC_RSTART = 6'b001000,
    TCC_RWAIT = 6'b010000,
    TCC_CMP = 6'b100000
  } tcc_state_t;

  tcc_state_t state; // current sequencer state
  tcc_state_t next_state;

  logic [1:0] chan_en; // local/remote enables
  logic [7:0] consec_code; // consecutive count register
  logic [7:0] ideality; // signed ideality adjustment
  logic [7:0] remote_ofs; // remote offset, integer degrees
  logic shot_pending; // single shot requested in shutdown
  logic local_done; // local result updated this cycle
  logic remote_load; // remote correction load strobe
  logic remote_done; // remote result updated this cycle
  logic alert_latch; // alert interrupt latch
  logic local_q; // local qualified over-limit
  logic remote_q; // remote qualified over-limit
  logic signed [W-1:0] remote_corr; // corrected remote result

  // register decode
  logic wr_chan, wr_consec, wr_ideal, wr_ofs, wr_shot;
  logic [7:0] rd_mux;
  logic local_on, remote_on;
  logic any_on;
  logic run_req; // a cycle should begin
  logic [2:0] need; // decoded consecutive count
  logic local_over, remote_over;
  logic any_flag; // qualified flags and open circuit

  // write strobes, one per writable register
  assign wr_chan = reg_wr && (reg_ptr == TCC_PTR_CHAN_EN);
  assign wr_consec = reg_wr && (reg_ptr == TCC_PTR_CONSEC);
  assign wr_ideal = reg_wr && (reg_ptr == TCC_PTR_IDEALITY);
  assign wr_ofs = reg_wr && (reg_ptr == TCC_PTR_REMOTE_OFS);
  // trigger write: only the pulse matters, data is dropped
  assign wr_shot = reg_wr && (reg_ptr == TCC_PTR_SINGLE_SHOT);

  // channel enables and the decoded consecutive count
  assign local_on = chan_en[TCC_LOCAL_ON_BIT];
  assign remote_on = chan_en[TCC_REMOTE_ON_BIT];
  assign any_on = local_on || remote_on;
  assign need = tcc_consec_decode(consec_code);

  // read data selection; unmapped and write-only pointers read zero
  always_comb begin
    case (reg_ptr)
      TCC_PTR_CHAN_EN: rd_mux = {6'h00, chan_en};
      TCC_PTR_CONSEC: rd_mux = consec_code;
      TCC_PTR_IDEALITY: rd_mux = ideality;
      TCC_PTR_REMOTE_OFS: rd_mux = remote_ofs;
      TCC_PTR_MAKER: rd_mux = MAKER_CODE;
      default: rd_mux = TCC_ZERO_BYTE;
    endcase
  end

  // continuous running unless shut down, else one pending shot
  assign run_req = any_on && (!stop_converting_bit || shot_pending);

  // next-state logic of the sequencer
  always_comb begin
    case (state)
      TCC_IDLE: begin
        if (run_req && local_on) begin
          next_state = TCC_LSTART;
        end else if (run_req) begin
          next_state = TCC_RSTART;
        end else begin
          next_state = TCC_IDLE;
        end
      end
      TCC_LSTART: next_state = TCC_LWAIT;
      TCC_LWAIT: begin
        if (!conv_done) begin
          next_state = TCC_LWAIT;
        end else if (remote_on) begin
          next_state = TCC_RSTART;
        end else begin
          next_state = TCC_CMP;
        end
      end
      TCC_RSTART: next_state = TCC_RWAIT;
      TCC_RWAIT: next_state = conv_done ? TCC_CMP : TCC_RWAIT;
      // sequence ends here; shutdown is only checked back in idle
      TCC_CMP: next_state = TCC_IDLE;
      default: next_state = TCC_IDLE;
    endcase
  end

  // sequencer state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TCC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // converter handshake outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      conv_start <= 1'b0;
      conv_remote_sel <= 1'b0;
      busy <= 1'b0;
    end else begin
      conv_start <= (next_state == TCC_LSTART) ||
                    (next_state == TCC_RSTART);
      conv_remote_sel <= (next_state == TCC_RSTART) ||
                         (next_state == TCC_RWAIT);
      busy <= (next_state != TCC_IDLE);
    end
  end

  // single shot request: set by a trigger in shutdown, used by one cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shot_pending <= 1'b0;
    end else if (wr_shot && stop_converting_bit) begin
      shot_pending <= 1'b1;
    end else if (state == TCC_IDLE && run_req) begin
      shot_pending <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      chan_en <= TCC_CHAN_EN_RST;
      consec_code <= TCC_CONSEC_RST;
      ideality <= TCC_IDEALITY_RST;
      remote_ofs <= TCC_OFS_RST;
    end else begin
      if (wr_chan) begin
        chan_en <= reg_wdata[1:0];
      end
      if (wr_consec) begin
        consec_code <= reg_wdata;
      end
      if (wr_ideal) begin
        ideality <= reg_wdata;
      end
      if (wr_ofs) begin
        remote_ofs <= reg_wdata;
      end
    end
  end

  // read data register, loaded on a read strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= TCC_ZERO_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // local result capture and result-ready strobes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      local_result <= '0;
      local_done <= 1'b0;
      remote_done <= 1'b0;
    end else begin
      local_done <= 1'b0;
      remote_done <= remote_load;
      if (state == TCC_LWAIT && conv_done) begin
        local_result <= conv_raw;
        local_done <= 1'b1;
      end
    end
  end

  // remote value is taken at the converter's done in remote wait
  assign remote_load = (state == TCC_RWAIT) && conv_done;

  // remote result: ideality scaling then offset
  tcc_remote_correct #(
    .W(W)
  ) u_correct (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(remote_load),
    .raw(conv_raw),
    .adjust(ideality),
    .offset(remote_ofs),
    .result(remote_corr)
  );

  // output copy of the stored remote result
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      remote_result <= '0;
    end else begin
      remote_result <= remote_corr;
    end
  end

  // limit comparisons against the freshly stored results
  assign local_over = (local_result > local_high_limit);
  assign remote_over = (remote_corr > remote_high_limit);

  // one counter per channel, both use the same programmed count
  tcc_consec_count u_local_cnt (
    .mclk(mclk),
    .rst_n(rst_n),
    .sample(local_done),
    .over(local_over),
    .need(need),
    .qualified(local_q)
  );

  // remote channel counter, fed by the corrected result
  tcc_consec_count u_remote_cnt (
    .mclk(mclk),
    .rst_n(rst_n),
    .sample(remote_done),
    .over(remote_over),
    .need(need),
    .qualified(remote_q)
  );

  // every condition that may set or hold the alert latch
  assign any_flag = local_q || remote_q || remote_open;

  // alert latch: a flag sets it; service clears it only once flags are
  // gone, and a set in the same cycle wins
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alert_latch <= 1'b0;
    end else if (any_flag) begin
      alert_latch <= 1'b1;
    end else if (alert_service) begin
      alert_latch <= 1'b0;
    end
  end

  // active-low alert pin from its own flop
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alert_n <= 1'b1;
    end else begin
      alert_n <= !(alert_latch || any_flag);
    end
  end

endmodule : tcc_conv_ctrl
`default_nettype wire

// File: tcc_conv_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
// watches the register port, converter link and alert output
module tcc_checker
  import tcc_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'hA5 // arbitrary value
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_ptr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic stop_converting_bit,
  input wire logic conv_start,
  input wire logic conv_remote_sel,
  input wire logic conv_done,
  input wire logic remote_open,
  input wire logic alert_service,
  input wire logic busy,
  input wire logic alert_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  start_busy_a: assert property (conv_start |-> busy)
    else $error("start outside a sequence");
  shut_quiet_a: assert property ($fell(busy) && stop_converting_bit
    && !reg_wr |-> !conv_start [*4]) else $error("start after shutdown");
  maker_read_a: assert property (reg_rd && reg_ptr == TCC_PTR_MAKER
    |=> reg_rdata == MAKER_CODE) else $error("maker code wrong");
  trig_read_a: assert property (reg_rd && reg_ptr == TCC_PTR_SINGLE_SHOT
    |=> reg_rdata == TCC_ZERO_BYTE) else $error("trigger data kept");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  remote_hold_a: assert property (conv_remote_sel && !conv_done
    |=> conv_remote_sel) else $error("remote select dropped");
  open_alert_a: assert property (remote_open |-> ##[1:3] !alert_n)
    else $error("open circuit without alert");
  alert_release_a: assert property ($rose(alert_n) |->
    $past(alert_service) || $past(alert_service, 2))
    else $error("alert released unserviced");
endmodule : tcc_checker
bind tcc_conv_ctrl tcc_checker #(.MAKER_CODE(MAKER_CODE)) tcc_checker_i (
  .mclk(mclk), .rst_n(rst_n), .reg_ptr(reg_ptr), .reg_rd(reg_rd),
  .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .stop_converting_bit(stop_converting_bit), .conv_start(conv_start),
  .conv_remote_sel(conv_remote_sel), .conv_done(conv_done),
  .remote_open(remote_open), .alert_service(alert_service), .busy(busy),
  .alert_n(alert_n));
`default_nettype wire

// File: tcc_conv_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
// bench: register calls, single shots, alert counts, continuous run
module tcc_conv_ctrl_tb import tcc_pkg::*;;
  localparam logic [7:0] MAKER = 8'hA5; // arbitrary value
  logic mclk, rst_n, reg_wr, reg_rd, stop_converting_bit, slow;
  logic remote_open, alert_service, conv_done, conv_start;
  logic conv_remote_sel, busy, alert_n;
  logic [7:0] reg_ptr, reg_wdata, reg_rdata;
  logic signed [15:0] conv_raw, local_val, remote_val, local_result;
  logic signed [15:0] local_high_limit, remote_high_limit, remote_result;
  int errors, check_count, cyc, starts, rstarts, exp_r;
  // reset-value table: pointer and expected read
  logic [7:0] ptrs [7] = '{8'h16, 8'h22, 8'h23, 8'h19, 8'hFE, 8'h0F, 8'h40};
  logic [7:0] exps [7] = '{8'h03, 8'h01, 8'h00, 8'h00, MAKER, 8'h00, 8'h00};
  tcc_conv_ctrl #(.MAKER_CODE(MAKER)) tcc_conv_ctrl_i (.mclk(mclk),
    .rst_n(rst_n), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_converting_bit(stop_converting_bit), .conv_start(conv_start),
    .conv_remote_sel(conv_remote_sel), .conv_done(conv_done),
    .conv_raw(conv_raw), .remote_open(remote_open),
    .local_high_limit(local_high_limit),
    .remote_high_limit(remote_high_limit), .alert_service(alert_service),
    .busy(busy), .alert_n(alert_n), .local_result(local_result),
    .remote_result(remote_result));
  tcc_conv_model tcc_conv_model_i (.mclk(mclk), .rst_n(rst_n),
    .conv_start(conv_start), .conv_remote_sel(conv_remote_sel),
    .slow(slow), .local_val(local_val), .remote_val(remote_val),
    .conv_done(conv_done), .conv_raw(conv_raw));
  // clock, 25 ns period
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // counts starts and remote starts; cuts a hang short
  always @(posedge mclk) begin
    cyc++;
    if (conv_start === 1'b1) starts++;
    if (conv_start === 1'b1 && conv_remote_sel === 1'b1) rstarts++;
    if (cyc == 20000) begin
      errors++;
      $display("MISMATCH %0t timeout", $time);
      stop_test();
    end
  end
  // compares and counts
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one register write
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    @(posedge mclk);
    reg_ptr <= p;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  // one register read, data checked 1 ns after it is taken
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    @(posedge mclk);
    reg_ptr <= p;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask : rd
  // wait for a sequence to start and go idle again
  task automatic settle();
    for (int i = 0; i < 6 && busy !== 1'b1; i++) @(posedge mclk);
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge mclk);
    repeat (4) @(posedge mclk);
    #1;
  endtask : settle
  // single shot with expected start counts
  task automatic shot(input int n, input int nr);
    starts = 0;
    rstarts = 0;
    wr(TCC_PTR_SINGLE_SHOT, 8'h5A);
    settle();
    chk(starts, n);
    chk(rstarts, nr);
  endtask : shot
  // local-only shot with a given raw value
  task automatic lshot(input logic signed [15:0] v);
    local_val <= v;
    shot(1, 0);
  endtask : lshot
  // pulses the alert service input and lets the alert pin settle
  task automatic service();
    @(posedge mclk);
    alert_service <= 1'b1;
    @(posedge mclk);
    alert_service <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask : service
  // prints counts and verdict
  task automatic stop_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  // main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, remote_open, alert_service, slow} = '0;
    stop_converting_bit = 1'b1;
    {reg_ptr, reg_wdata} = '0;
    local_val = 16'sh0080;
    remote_val = 16'sh1000;
    local_high_limit = 16'sh0100;
    remote_high_limit = 16'sh7FFF;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    for (int k = 0; k < 7; k++) rd(ptrs[k], exps[k]);
    chk(starts, 0);
    wr(TCC_PTR_CHAN_EN, 8'hFF);
    rd(TCC_PTR_CHAN_EN, 8'h03);
    foreach (exps[k]) begin
      wr(TCC_PTR_CONSEC, {4'h0, 4'hF >> k % 4});
      rd(TCC_PTR_CONSEC, {4'h0, 4'hF >> k % 4});
    end
    wr(TCC_PTR_IDEALITY, 8'h80);
    rd(TCC_PTR_IDEALITY, 8'h80);
    wr(TCC_PTR_REMOTE_OFS, 8'h02);
    slow <= 1'b1;
    shot(2, 1);
    rd(TCC_PTR_SINGLE_SHOT, 8'h00);
    exp_r = int'(remote_val) * (TCC_IDEAL_BASE - 128) / TCC_IDEAL_BASE + 512;
    chk(remote_result, exp_r[15:0]);
    chk(local_result, local_val);
    slow <= 1'b0;
    wr(TCC_PTR_CHAN_EN, 8'h02);
    shot(1, 1);
    wr(TCC_PTR_CHAN_EN, 8'h01);
    wr(TCC_PTR_CONSEC, TCC_CONSEC_2);
    lshot(16'sh0200);
    chk(alert_n, 1'b1);
    lshot(16'sh0200);
    chk(alert_n, 1'b0);
    lshot(16'sh0000);
    service();
    chk(alert_n, 1'b1);
    wr(TCC_PTR_CONSEC, TCC_CONSEC_3);
    lshot(16'sh0200);
    lshot(16'sh0000);
    lshot(16'sh0200);
    lshot(16'sh0200);
    chk(alert_n, 1'b1);
    lshot(16'sh0200);
    chk(alert_n, 1'b0);
    service();
    chk(alert_n, 1'b0);
    wr(TCC_PTR_CHAN_EN, 8'h03);
    starts = 0;
    stop_converting_bit <= 1'b0;
    repeat (300) @(posedge mclk);
    chk(starts >= 6, 1'b1);
    stop_converting_bit <= 1'b1;
    settle();
    starts = 0;
    repeat (100) @(posedge mclk);
    chk(starts, 0);
    local_val <= 16'sh0000;
    shot(2, 1);
    service();
    chk(alert_n, 1'b1);
    remote_open <= 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    chk(alert_n, 1'b0);
    remote_open <= 1'b0;
    service();
    chk(alert_n, 1'b1);
    remote_high_limit <= 16'sh0100;
    wr(TCC_PTR_CONSEC, TCC_CONSEC_1);
    shot(2, 1);
    chk(alert_n, 1'b0);
    stop_test();
  end
endmodule : tcc_conv_ctrl_tb
`default_nettype wire

// File: tcc_conv_model.sv
`timescale 1ns/10ps
`default_nettype none
// behavioural converter: answers each start after a few cycles
module tcc_conv_model
  import tcc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic conv_start,
  input wire logic conv_remote_sel,
  input wire logic slow,
  input wire logic signed [TCC_RES_W-1:0] local_val,
  input wire logic signed [TCC_RES_W-1:0] remote_val,
  output logic conv_done,
  output logic signed [TCC_RES_W-1:0] conv_raw
);
  int wait_cnt; // cycles left until the answer
  logic signed [TCC_RES_W-1:0] last_raw; // value handed over last
  // raw value is only valid with done; otherwise it shows the inverse
  assign conv_raw = conv_done ? last_raw : ~last_raw;
  // count down after a start, then pulse done with the selected channel
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 0;
      conv_done <= 1'b0;
      last_raw <= '0;
    end else if (conv_start) begin
      wait_cnt <= slow ? 12 : 3;
      conv_done <= 1'b0;
    end else if (wait_cnt == 1) begin
      wait_cnt <= 0;
      conv_done <= 1'b1;
      last_raw <= conv_remote_sel ? remote_val : local_val;
    end else begin
      wait_cnt <= (wait_cnt > 0) ? wait_cnt - 1 : 0;
      conv_done <= 1'b0;
    end
  end
endmodule : tcc_conv_model
`default_nettype wire

// File: tcc_pkg.sv
// shared constants for the conversion control and calibration block
package tcc_pkg;
  // pointer addresses
  localparam logic [7:0] TCC_PTR_SINGLE_SHOT = 8'h0F;
  localparam logic [7:0] TCC_PTR_CHAN_EN = 8'h16;
  localparam logic [7:0] TCC_PTR_CONSEC = 8'h22;
  localparam logic [7:0] TCC_PTR_IDEALITY = 8'h23;
  localparam logic [7:0] TCC_PTR_REMOTE_OFS = 8'h19;
  localparam logic [7:0] TCC_PTR_MAKER = 8'hFE;
  // field positions in the channel enable register
  localparam int TCC_LOCAL_ON_BIT = 0;
  localparam int TCC_REMOTE_ON_BIT = 1;
  // reset values
  localparam logic [1:0] TCC_CHAN_EN_RST = 2'h3;
  localparam logic [7:0] TCC_CONSEC_RST = 8'h01;
  localparam logic [7:0] TCC_IDEALITY_RST = 8'h00;
  localparam logic [7:0] TCC_OFS_RST = 8'h00;
  localparam logic [7:0] TCC_ZERO_BYTE = 8'h00;
  // thermometer codes of the consecutive count register
  localparam logic [7:0] TCC_CONSEC_1 = 8'h01;
  localparam logic [7:0] TCC_CONSEC_2 = 8'h03;
  localparam logic [7:0] TCC_CONSEC_3 = 8'h07;
  localparam logic [7:0] TCC_CONSEC_4 = 8'h0F;
  // ideality base count of the correction formula
  localparam int TCC_IDEAL_BASE = 2088;
  // result width, two's complement, 1/256 degree per lsb
  localparam int TCC_RES_W = 16;

  // decode a consecutive count byte into a number of results (1..4)
  function automatic logic [2:0] tcc_consec_decode(input logic [7:0] code);
    case (code)
      TCC_CONSEC_2: tcc_consec_decode = 3'h2;
      TCC_CONSEC_3: tcc_consec_decode = 3'h3;
      TCC_CONSEC_4: tcc_consec_decode = 3'h4;
      default: tcc_consec_decode = 3'h1;
    endcase
  endfunction : tcc_consec_decode
endpackage : tcc_pkg

// File: tcc_remote_correct.sv
`timescale 1ns/10ps
`default_nettype none
// ideality scaling and offset addition for a remote result
module tcc_remote_correct
  import tcc_pkg::*;
#(
  parameter int W = TCC_RES_W
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic signed [W-1:0] raw,
  input wire logic signed [7:0] adjust,
  input wire logic signed [7:0] offset,
  output logic signed [W-1:0] result
);
  localparam logic signed [12:0] BASE = 13'(TCC_IDEAL_BASE);
  logic signed [12:0] denom; // base plus signed adjustment
  logic signed [W+13:0] scaled; // raw times denominator
  logic signed [W+13:0] ratio; // divided back by the base
  logic signed [W+13:0] with_ofs; // offset in integer degrees

  // raw is taken at factor 1.008; eff = 1.008*base/(base+n), so the
  // measured temperature scales by (base+n)/base
  assign denom = BASE + 13'(adjust);
  assign scaled = (W+14)'(raw) * (W+14)'(denom);
  assign ratio = scaled / (W+14)'(BASE);
  assign with_ofs = ratio +
                    (W+14)'(signed'({offset, TCC_ZERO_BYTE}));

  // register the corrected result
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      result <= '0;
    end else if (load) begin
      result <= with_ofs[W-1:0];
    end
  end
endmodule : tcc_remote_correct
`default_nettype wire
